/* File: rtl/dbp_pkg.sv */
package dbp_pkg;
  // Register indices; byte address is index times four.
  localparam logic [7:0] DBP_IDX_H_DIR  = 8'h10;
  localparam logic [7:0] DBP_IDX_H_DATA = 8'h11;
  localparam logic [7:0] DBP_IDX_J_DIR  = 8'h12;
  localparam logic [7:0] DBP_IDX_J_DATA = 8'h13;
  localparam logic [7:0] DBP_IDX_ACFG   = 8'h15;
  localparam logic [7:0] DBP_IDX_RMW    = 8'h16;
  localparam logic [7:0] DBP_IDX_RESET  = 8'h17;

  localparam int unsigned DBP_ADDR_LSB = 2;
  localparam int unsigned DBP_IDX_W    = 8;

  localparam logic [7:0] DBP_DIR_RST      = 8'hff;
  localparam logic [7:0] DBP_ACFG_RST     = 8'h00;
  localparam logic [7:0] DBP_ACFG_MASK    = 8'hef;
  localparam logic [3:0] DBP_H_UPPER_RST  = 4'h0;
  localparam logic [7:0] DBP_J_COLD_RST   = 8'h00;
  localparam logic [3:0] DBP_H_LOWER_COLD = 4'h0;

  // Analog pin config field: values below this code keep port H upper pins analog.
  localparam logic [3:0] DBP_PCFG_DIGITAL = 4'he;
  localparam int unsigned DBP_PCFG_LSB    = 0;

  // Read-modify-write operation codes, data byte bits 9:8 and bit index 12:10.
  localparam int unsigned DBP_RMW_OP_LSB  = 8;
  localparam int unsigned DBP_RMW_BIT_LSB = 10;
  localparam int unsigned DBP_RMW_PORT_B  = 13;

  typedef enum logic [1:0] {
    DBP_OP_CLR = 2'b00,
    DBP_OP_SET = 2'b01,
    DBP_OP_TGL = 2'b10,
    DBP_OP_AND = 2'b11
  } dbp_op_t;

  // Reset cause codes written to the reset register.
  localparam logic [1:0] DBP_RST_COLD = 2'b01;
  localparam logic [1:0] DBP_RST_WARM = 2'b10;

  typedef enum logic [1:0] {
    DBP_ST_IDLE = 2'b00,
    DBP_ST_ACK  = 2'b01
  } dbp_state_t;
endpackage

/* File: rtl/dbp_port.sv */
`timescale 1ns/1ps
module dbp_port
  import dbp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  dbp_port_if.port  p
);
  logic [7:0] dir_reg;
  logic [7:0] lat_reg;

  assign p.dir = dir_reg;
  assign p.lat = lat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || p.cold || p.warm) begin
      dir_reg <= DBP_DIR_RST;
    end else if (p.wr_dir) begin
      dir_reg <= p.wr_data;
    end
  end

  // Reset keeps bits flagged in keep_rst on a warm reset; every cold reset loads lat_rst.
  always_ff @(posedge clk_i) begin
    if (rst_i || p.cold) begin
      lat_reg <= p.lat_rst;
    end else if (p.warm) begin
      lat_reg <= (lat_reg & p.keep_rst) | (p.lat_rst & ~p.keep_rst);
    end else if (p.wr_lat) begin
      lat_reg <= p.wr_data;
    end
  end
endmodule

/* File: rtl/dbp_port_if.sv */
`timescale 1ns/1ps
interface dbp_port_if;
  logic [7:0] wr_data;
  logic       wr_dir;
  logic       wr_lat;
  logic       cold;
  logic       warm;
  logic [7:0] keep_rst;
  logic [7:0] lat_rst;
  logic [7:0] dir;
  logic [7:0] lat;
  modport ctl (output wr_data, wr_dir, wr_lat, cold, warm, keep_rst, lat_rst,
               input dir, lat);
  modport port (input wr_data, wr_dir, wr_lat, cold, warm, keep_rst, lat_rst,
                output dir, lat);
endinterface

/* File: rtl/dbp_top.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// Functional notes
// - Two 8-bit ports; direction bit one means input, zero means output.
// - Data reads return pin levels; data writes update only the output latch.
// - Read-modify-write samples all pins, applies the bit op, writes whole latch.
// - Writes land at cycle end; reads sample pins at cycle start.
// - Both direction registers reset to all ones on every reset kind.
// - Port H upper latch resets to zero; lower bits kept on warm reset.
// - Port J latch cleared to zero on cold reset, kept on warm reset.
// - Direction/data of H then J decode at indices 10h to 13h.
// - Port H upper pins are analog after reset until config reprogrammed.
module dbp_top
  import dbp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Port H pins
  input  wire logic [7:0]  port_h_pin_i,
  output logic      [7:0]  port_h_pin_o,
  output logic      [7:0]  port_h_pin_oe_o,
  output logic      [3:0]  port_h_analog_o,
  // Port J pins
  input  wire logic [7:0]  port_j_pin_i,
  output logic      [7:0]  port_j_pin_o,
  output logic      [7:0]  port_j_pin_oe_o
);
  dbp_port_if h_if ();
  dbp_port_if j_if ();

  dbp_state_t state_reg;
  dbp_state_t state_next;
  logic [7:0] acfg_reg;
  logic [7:0] h_samp_reg;
  logic [7:0] j_samp_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        cold_reg;
  logic        warm_reg;
  logic [7:0]  h_pin_o_reg;
  logic [7:0]  h_oe_reg;
  logic [3:0]  h_ana_reg;
  logic [7:0]  j_pin_o_reg;
  logic [7:0]  j_oe_reg;

  // Decode.
  wire [DBP_IDX_W-1:0] idx      = adr_i[DBP_ADDR_LSB +: DBP_IDX_W];
  wire                 req      = cyc_i && stb_i && (state_reg == DBP_ST_IDLE);
  wire                 wr_ok    = req && we_i && sel_i[0];
  wire                 hit_hdir = (idx == DBP_IDX_H_DIR);
  wire                 hit_hdat = (idx == DBP_IDX_H_DATA);
  wire                 hit_jdir = (idx == DBP_IDX_J_DIR);
  wire                 hit_jdat = (idx == DBP_IDX_J_DATA);
  wire                 hit_acfg = (idx == DBP_IDX_ACFG);
  wire                 hit_rmw  = (idx == DBP_IDX_RMW);
  wire                 hit_rst  = (idx == DBP_IDX_RESET);

  // Read-modify-write request fields.
  wire          rmw_on_j = dat_i[DBP_RMW_PORT_B];
  wire [2:0]    rmw_bit  = dat_i[DBP_RMW_BIT_LSB +: 3];
  wire dbp_op_t rmw_op   = dbp_op_t'(dat_i[DBP_RMW_OP_LSB +: 2]);
  wire [7:0]    rmw_src  = rmw_on_j ? j_samp_reg : h_samp_reg;
  wire [7:0]    rmw_mask = 8'h01 << rmw_bit;
  logic [7:0]   rmw_res;

  always_comb begin
    case (rmw_op)
      DBP_OP_CLR: rmw_res = rmw_src & ~rmw_mask;
      DBP_OP_SET: rmw_res = rmw_src | rmw_mask;
      DBP_OP_TGL: rmw_res = rmw_src ^ rmw_mask;
      DBP_OP_AND: rmw_res = rmw_src & dat_i[7:0];
      default:    rmw_res = rmw_src;
    endcase
  end

  wire rmw_go = wr_ok && hit_rmw && sel_i[1];

  // Port write strobes; data and direction writes land at the acknowledge edge, reset pulses one edge after it.
  assign h_if.wr_data = rmw_go ? rmw_res : dat_i[7:0];
  assign j_if.wr_data = rmw_go ? rmw_res : dat_i[7:0];
  assign h_if.wr_dir  = wr_ok && hit_hdir;
  assign j_if.wr_dir  = wr_ok && hit_jdir;
  assign h_if.wr_lat  = (wr_ok && hit_hdat) || (rmw_go && !rmw_on_j);
  assign j_if.wr_lat  = (wr_ok && hit_jdat) || (rmw_go && rmw_on_j);
  assign h_if.cold    = cold_reg;
  assign j_if.cold    = cold_reg;
  assign h_if.warm    = warm_reg;
  assign j_if.warm    = warm_reg;
  assign h_if.keep_rst = 8'h0f;
  assign h_if.lat_rst  = {DBP_H_UPPER_RST, DBP_H_LOWER_COLD};
  assign j_if.keep_rst = 8'hff;
  assign j_if.lat_rst  = DBP_J_COLD_RST;

  dbp_port u_port_h (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .p     (h_if.port)
  );

  dbp_port u_port_j (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .p     (j_if.port)
  );

  // Read data mux; port data reads return sampled pins.
  always_comb begin
    dat_next = 32'h0000_0000;
    if (hit_hdir) begin
      dat_next[7:0] = h_if.dir;
    end else if (hit_hdat) begin
      dat_next[7:0] = h_samp_reg;
    end else if (hit_jdir) begin
      dat_next[7:0] = j_if.dir;
    end else if (hit_jdat) begin
      dat_next[7:0] = j_samp_reg;
    end else if (hit_acfg) begin
      dat_next[7:0] = acfg_reg;
    end else begin
      dat_next = 32'h0000_0000;
    end
  end

  always_comb begin
    case (state_reg)
      DBP_ST_IDLE: state_next = req ? DBP_ST_ACK : DBP_ST_IDLE;
      DBP_ST_ACK:  state_next = DBP_ST_IDLE;
      default:     state_next = DBP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= DBP_ST_IDLE;
      ack_o     <= 1'b0;
      dat_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      ack_o     <= req;
      dat_reg   <= req ? dat_next : 32'h0000_0000;
    end
  end

  assign dat_o = dat_reg;

  // Pins are sampled every cycle; a read sees the level captured before the access,
  // so a read right after a write to the same port can still show the old level.
  always_ff @(posedge clk_i) begin
    h_samp_reg <= port_h_pin_i;
    j_samp_reg <= port_j_pin_i;
  end

  // Analog configuration, written byte-wide; bit 4 stays unimplemented.
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_reg || warm_reg) begin
      acfg_reg <= DBP_ACFG_RST;
    end else if (wr_ok && hit_acfg) begin
      acfg_reg <= dat_i[7:0] & DBP_ACFG_MASK;
    end
  end

  // Software-issued reset pulses model cold and warm resets for the ports.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cold_reg <= 1'b0;
      warm_reg <= 1'b0;
    end else begin
      cold_reg <= wr_ok && hit_rst && (dat_i[1:0] == DBP_RST_COLD);
      warm_reg <= wr_ok && hit_rst && (dat_i[1:0] == DBP_RST_WARM);
    end
  end

  wire h_upper_analog = acfg_reg[DBP_PCFG_LSB +: 4] < DBP_PCFG_DIGITAL;

  // Pin drivers; upper H pins never drive while analog.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_pin_o_reg <= 8'h00;
      h_oe_reg    <= 8'h00;
      h_ana_reg   <= 4'hf;
      j_pin_o_reg <= 8'h00;
      j_oe_reg    <= 8'h00;
    end else begin
      h_pin_o_reg <= h_if.lat;
      h_oe_reg    <= ~h_if.dir & {{4{~h_upper_analog}}, 4'hf};
      h_ana_reg   <= {4{h_upper_analog}};
      j_pin_o_reg <= j_if.lat;
      j_oe_reg    <= ~j_if.dir;
    end
  end

  assign port_h_pin_o    = h_pin_o_reg;
  assign port_h_pin_oe_o = h_oe_reg;
  assign port_h_analog_o = h_ana_reg;
  assign port_j_pin_o    = j_pin_o_reg;
  assign port_j_pin_oe_o = j_oe_reg;
endmodule

/* File: verification/dbp_chk.sv */
`timescale 1ns/1ps
module dbp_chk
  import dbp_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Pins
  input wire logic [7:0]  port_h_pin_i,
  input wire logic [7:0]  port_h_pin_o,
  input wire logic [7:0]  port_h_pin_oe_o,
  input wire logic [3:0]  port_h_analog_o,
  input wire logic [7:0]  port_j_pin_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire       take = cyc_i && stb_i && !ack_o;
  wire [7:0] idx  = adr_i[9:2];
  wire       wr0  = take && we_i && sel_i[0];

  property p_ack; take |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_unmap; take && !we_i && idx == 8'h14 |=> dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Reset must be seen even while it is held, so the default disable is overridden.
  property p_rst;
    disable iff (1'h0) rst_i |=> port_h_pin_oe_o == 8'h00 && port_j_pin_oe_o == 8'h00
      && port_h_analog_o == 4'hf;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_analog; (port_h_pin_oe_o[7:4] & port_h_analog_o) == 4'h0; endproperty
  a_analog: assert property (p_analog) else $error("analog pin driven");
  property p_hdata;
    wr0 && idx == DBP_IDX_H_DATA |=> ##1 port_h_pin_o == $past(dat_i[7:0], 2);
  endproperty
  a_hdata: assert property (p_hdata) else $error("latch not updated");
  property p_jdir;
    wr0 && idx == DBP_IDX_J_DIR |=> ##1 port_j_pin_oe_o == ~$past(dat_i[7:0], 2);
  endproperty
  a_jdir: assert property (p_jdir) else $error("direction not applied");
  property p_read;
    take && !we_i && idx == DBP_IDX_H_DATA |=> dat_o[7:0] == $past(port_h_pin_i, 2);
  endproperty
  a_read: assert property (p_read) else $error("pin read wrong");
  property p_warm;
    wr0 && idx == DBP_IDX_RESET && dat_i[1:0] == DBP_RST_WARM |=> ##2
      port_h_pin_oe_o == 8'h00 && port_h_pin_o[7:4] == 4'h0;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset wrong");
endmodule

/* File: verification/dbp_pins.sv */
`timescale 1ns/1ps
module dbp_pins (
  // Port side and outside circuitry
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  // The outside circuit only drives released pins, so there is never contention.
  assign pin_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule

/* File: verification/test_dbp_top.sv */
`timescale 1ns/1ps
module test_dbp_top;
  import dbp_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [11:0] adr_i;
  logic [3:0]  sel_i, port_h_analog_o;
  logic [31:0] dat_i, dat_o;
  logic [7:0]  port_h_pin_i, port_h_pin_o, port_h_pin_oe_o, ext_h, q;
  logic [7:0]  port_j_pin_i, port_j_pin_o, port_j_pin_oe_o, ext_j;
  int          fails, n_tests;
  // Rows: write flag, index, write byte, expected read byte.
  logic [27:0] rows [16] = '{28'h0_10_00_ff, 28'h0_12_00_ff, 28'h0_15_00_00,
    28'h1_13_5a_00, 28'h1_12_0f_00, 28'h0_12_00_0f, 28'h0_13_00_53, 28'h1_15_0e_00,
    28'h0_15_00_0e, 28'h1_11_a5_00, 28'h0_11_00_3c, 28'h1_10_00_00, 28'h0_11_00_a5,
    28'h0_14_00_00, 28'h1_15_ff_00, 28'h0_15_00_ef};

  dbp_top dbp_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .port_h_pin_i, .port_h_pin_o, .port_h_pin_oe_o, .port_h_analog_o,
    .port_j_pin_i, .port_j_pin_o, .port_j_pin_oe_o);
  dbp_pins dbp_pins_h (.drv_i(port_h_pin_o), .oe_i(port_h_pin_oe_o), .ext_i(ext_h),
    .pin_o(port_h_pin_i));
  dbp_pins dbp_pins_j (.drv_i(port_j_pin_o), .oe_i(port_j_pin_oe_o), .ext_i(ext_j),
    .pin_o(port_j_pin_i));

  always #25 clk_i = ~clk_i;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Each access leaves one idle cycle, which also keeps a write apart from a read.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [7:0] r);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    sel_i <= 4'h3;
    adr_i <= {2'h0, a, 2'h0};
    dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    r = dat_o[7:0];
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  initial begin
    repeat (4000) @(posedge clk_i);
    fails++;
    finish_test();
  end

  initial begin
    {clk_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'h1;
    ext_h = 8'h3c;
    ext_j = 8'h33;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      bus(rows[i][24], rows[i][23:16], {8'h00, rows[i][15:8]}, q);
      if (!rows[i][24]) chk("row read", rows[i][7:0], q);
    end
    ext_h <= 8'h0c;
    bus(1'h1, DBP_IDX_H_DIR, 16'h000f, q);
    bus(1'h1, DBP_IDX_RMW, 16'h0100, q);
    bus(1'h1, DBP_IDX_H_DIR, 16'h0000, q);
    bus(1'h0, DBP_IDX_H_DATA, 16'h0000, q);
    chk("set on pins", 8'had, q);
    bus(1'h1, DBP_IDX_RMW, 16'h3e00, q);
    @(negedge clk_i);
    chk("toggle on pins", 8'hd3, port_j_pin_o);
    @(posedge clk_i);
    bus(1'h1, DBP_IDX_RESET, 16'h0002, q);
    @(negedge clk_i);
    chk("warm h latch", 8'h0d, port_h_pin_o);
    chk("warm j latch", 8'hd3, port_j_pin_o);
    chk("warm analog", 8'h0f, {4'h0, port_h_analog_o});
    chk("warm j oe", 8'h00, port_j_pin_oe_o);
    @(posedge clk_i);
    bus(1'h1, DBP_IDX_H_DIR, 16'h0000, q);
    @(negedge clk_i);
    chk("analog h oe", 8'h0f, port_h_pin_oe_o);
    @(posedge clk_i);
    bus(1'h1, DBP_IDX_RMW, 16'h0306, q);
    bus(1'h1, DBP_IDX_RMW, 16'h2000, q);
    @(negedge clk_i);
    chk("and on pins", 8'h04, port_h_pin_o);
    chk("clear on pins", 8'h32, port_j_pin_o);
    @(posedge clk_i);
    bus(1'h1, DBP_IDX_RESET, 16'h0001, q);
    @(negedge clk_i);
    chk("cold h latch", 8'h00, port_h_pin_o);
    chk("cold j latch", 8'h00, port_j_pin_o);
    @(posedge clk_i);
    bus(1'h1, DBP_IDX_J_DATA, 16'h005a, q);
    bus(1'h1, DBP_IDX_J_DIR, 16'h0000, q);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("reset j latch", 8'h00, port_j_pin_o);
    chk("reset j oe", 8'h00, port_j_pin_oe_o);
    @(posedge clk_i);
    bus(1'h0, DBP_IDX_J_DIR, 16'h0000, q);
    chk("reset j dir", 8'hff, q);
    finish_test();
  end
endmodule

bind dbp_top dbp_chk dbp_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .port_h_pin_i, .port_h_pin_o, .port_h_pin_oe_o,
  .port_h_analog_o, .port_j_pin_oe_o);
